//--- verilog/double_rank_digital_output.sv
// sixteen channel double buffered digital output port.
// assumes a single-cycle strobe register port with read data one cycle later.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module double_rank_digital_output
  import dro_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [31:0]       reg_rdata,
  input  wire logic              transfer_trigger_input,
  input  wire logic              system_trigger_event,
  output logic      [WIDTH-1:0]  channel_out,
  output logic                   word_write_ready,
  output logic                   transfer_pulse
);
  logic [WIDTH-1:0] first_rank;
  logic [WIDTH-1:0] pend_word;
  logic             pending;
  logic             stalled;
  source_t          transfer_trigger_source;
  pacing_t          write_pacing_mode;
  logic [7:0]       error_code;
  logic [7:0]       list_count;
  logic             ext_fall;
  logic             one_shot_fire;
  logic             write_done;
  logic             word_wr;
  logic             chan_wr;
  logic             src_wr;
  logic             word_load;
  logic             chan_bit;
  logic [3:0]       chan_sel;
  source_t          next_source;
  wstate_t          wstate;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction : hit

  assign word_wr  = reg_write & hit(reg_addr, SLOT_WORD_ADDR);
  assign chan_wr  = reg_write & hit(reg_addr, CHANNEL_ADDR);
  assign src_wr   = reg_write & hit(reg_addr, SOURCE_ADDR);
  assign chan_sel = reg_wdata[CH_SEL_MSB:CH_SEL_LSB];
  assign chan_bit = |reg_wdata[31:CH_VAL_LSB];

  // bare select (given bit clear) means one-shot
  always_comb begin
    if (reg_wdata[SRC_GIVEN_BIT]) begin
      next_source = source_t'(reg_wdata[SRC_MSB:SRC_LSB]);
    end else begin
      next_source = SRC_ONE_SHOT;
    end
  end

  // wait pacing stalls only when a value is untransferred and source is not write
  wire wait_block = (write_pacing_mode == PACE_WAIT) && pending
                    && (transfer_trigger_source != SRC_WRITE);
  assign word_write_ready = (wstate == WS_IDLE);

  // word write state: idle or stalled holding a word
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wstate    <= WS_IDLE;
      pend_word <= OUT_RESET;
    end else begin
      unique case (wstate)
        WS_IDLE: begin
          if (word_wr && wait_block) begin
            wstate    <= WS_STALL;
            pend_word <= reg_wdata[WIDTH-1:0];
          end
        end
        WS_STALL: begin
          if (transfer_pulse) begin
            wstate <= WS_IDLE;
          end
        end
        default: wstate <= WS_IDLE;
      endcase
    end
  end
  assign stalled = (wstate == WS_STALL);

  // a word is loaded now, or when the stall is released by a transfer
  assign word_load = (word_wr && !wait_block && !stalled) || (stalled && transfer_pulse);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      first_rank <= OUT_RESET;
    end else if (stalled && transfer_pulse) begin
      first_rank <= pend_word;
    end else if (word_load) begin
      first_rank <= reg_wdata[WIDTH-1:0];
    end else if (chan_wr) begin
      first_rank[chan_sel] <= chan_bit;
    end
  end

  // write-generated trigger fires the cycle after the load
  always_ff @(posedge core_clk) begin
    if (reset) begin
      write_done <= 1'b0;
    end else begin
      write_done <= (word_load || chan_wr) && (transfer_trigger_source == SRC_WRITE);
    end
  end

  // source register; one-shot fires on selection, write-generated does not
  always_ff @(posedge core_clk) begin
    if (reset) begin
      transfer_trigger_source <= SRC_WRITE;
      one_shot_fire           <= 1'b0;
    end else begin
      one_shot_fire <= 1'b0;
      if (src_wr) begin
        transfer_trigger_source <= next_source;
        one_shot_fire           <= (next_source == SRC_ONE_SHOT);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      write_pacing_mode <= PACE_IMMEDIATE;
    end else if (reg_write && hit(reg_addr, PACING_ADDR)) begin
      write_pacing_mode <= pacing_t'(reg_wdata[0]);
    end
  end

  fall_detect u_fall (
    .core_clk   (core_clk),
    .reset      (reset),
    .pin_in     (transfer_trigger_input),
    .fall_pulse (ext_fall)
  );

  always_comb begin
    unique case (transfer_trigger_source)
      SRC_HOLD:     transfer_pulse = 1'b0;
      SRC_EXTERNAL: transfer_pulse = ext_fall;
      SRC_WRITE:    transfer_pulse = write_done;
      SRC_ONE_SHOT: transfer_pulse = one_shot_fire;
      SRC_SYSTEM:   transfer_pulse = system_trigger_event;
      default:      transfer_pulse = 1'b0;
    endcase
  end

  second_rank u_rank (
    .core_clk    (core_clk),
    .reset       (reset),
    .transfer    (transfer_pulse),
    .first_rank  (first_rank),
    .channel_out (channel_out)
  );

  // untransferred flag: set by a load wins over the trigger clearing it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pending <= 1'b0;
    end else if (word_load || chan_wr) begin
      pending <= 1'b1;
    end else if (transfer_pulse) begin
      pending <= 1'b0;
    end
  end

  // list count: software loads number of slots; each word consumes one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      list_count <= LIST_COUNT_RESET;
      error_code <= ERR_NONE;
    end else if (reg_write && hit(reg_addr, LIST_COUNT_ADDR)) begin
      list_count <= reg_wdata[7:0];
      error_code <= ERR_NONE;
    end else if (reg_write && hit(reg_addr, ERROR_ADDR)) begin
      error_code <= ERR_NONE;
    end else if (word_wr && list_count == 8'h01) begin
      list_count <= 8'hFF;
    end else if (word_wr && list_count == 8'hFF) begin
      error_code <= ERR_TOO_MANY_ARGS;
    end else if (word_wr && list_count != LIST_COUNT_RESET) begin
      list_count <= list_count - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      unique case (reg_addr)
        SOURCE_ADDR:      reg_rdata <= {29'h0, transfer_trigger_source};
        PACING_ADDR:      reg_rdata <= {31'h0, write_pacing_mode};
        STATUS_ADDR:      reg_rdata <= {29'h0, write_pacing_mode, stalled, pending};
        FIRST_RANK_ADDR:  reg_rdata <= {16'h0, first_rank};
        SECOND_RANK_ADDR: reg_rdata <= {16'h0, channel_out};
        ERROR_ADDR:       reg_rdata <= {24'h0, error_code};
        LIST_COUNT_ADDR:  reg_rdata <= {24'h0, list_count};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  property p_write_trig;
    @(posedge core_clk) disable iff (reset)
    (word_wr && transfer_trigger_source == SRC_WRITE && !stalled) |=> transfer_pulse;
  endproperty
  a_write_trig: assert property (p_write_trig)
    else $error("write-generated trigger missing");
  property p_hold_none;
    @(posedge core_clk) disable iff (reset)
    transfer_trigger_source == SRC_HOLD |-> !transfer_pulse;
  endproperty
  a_hold_none: assert property (p_hold_none)
    else $error("trigger under hold source");
  property p_one_shot;
    @(posedge core_clk) disable iff (reset)
    (src_wr && next_source == SRC_ONE_SHOT) |=> transfer_pulse ##1 !transfer_pulse;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot not exactly one trigger");
  property p_no_int_sel;
    @(posedge core_clk) disable iff (reset)
    (src_wr && next_source == SRC_WRITE && !word_load && !chan_wr && !write_done)
    |=> !transfer_pulse;
  endproperty
  a_no_int_sel: assert property (p_no_int_sel)
    else $error("selecting write source triggered");
  property p_stall;
    @(posedge core_clk) disable iff (reset)
    (word_wr && wait_block && !stalled) |=> stalled && $stable(first_rank);
  endproperty
  a_stall: assert property (p_stall)
    else $error("wait pacing did not stall");
  property p_stall_release;
    @(posedge core_clk) disable iff (reset)
    (stalled && transfer_pulse) |=> !stalled && first_rank == $past(pend_word);
  endproperty
  a_stall_release: assert property (p_stall_release)
    else $error("stalled word not loaded on transfer");
  property p_immed;
    @(posedge core_clk) disable iff (reset)
    (word_wr && write_pacing_mode == PACE_IMMEDIATE && !stalled)
    |=> first_rank == $past(reg_wdata[WIDTH-1:0]);
  endproperty
  a_immed: assert property (p_immed)
    else $error("immediate write lost");
  property p_chan_bit;
    @(posedge core_clk) disable iff (reset)
    (chan_wr && !stalled)
    |=> first_rank[$past(reg_wdata[CH_SEL_MSB:CH_SEL_LSB])]
        == (|$past(reg_wdata[31:CH_VAL_LSB]));
  endproperty
  a_chan_bit: assert property (p_chan_bit)
    else $error("channel write bit wrong");
  property p_sys;
    @(posedge core_clk) disable iff (reset)
    (transfer_trigger_source == SRC_SYSTEM && system_trigger_event) |-> transfer_pulse;
  endproperty
  a_sys: assert property (p_sys)
    else $error("system trigger missed");
  property p_excess;
    @(posedge core_clk) disable iff (reset)
    (word_wr && list_count == 8'hFF) |=> error_code == ERR_TOO_MANY_ARGS;
  endproperty
  a_excess: assert property (p_excess)
    else $error("excess word not flagged");
endmodule : double_rank_digital_output

//--- include/dro_pkg.sv
// package for the double rank digital output port: register map, codes, timing.
// assumes one 25 MHz clock and a simple strobe register port.
package dro_pkg;
  localparam int unsigned WIDTH             = 16;
  localparam int unsigned ADDR_W            = 4;
  localparam logic [3:0]  SLOT_WORD_ADDR    = 4'h0;
  localparam logic [3:0]  CHANNEL_ADDR      = 4'h1;
  localparam logic [3:0]  SOURCE_ADDR       = 4'h2;
  localparam logic [3:0]  PACING_ADDR       = 4'h3;
  localparam logic [3:0]  STATUS_ADDR       = 4'h4;
  localparam logic [3:0]  FIRST_RANK_ADDR   = 4'h5;
  localparam logic [3:0]  SECOND_RANK_ADDR  = 4'h6;
  localparam logic [3:0]  ERROR_ADDR        = 4'h7;
  localparam logic [3:0]  LIST_COUNT_ADDR   = 4'h8;
  localparam int unsigned CH_SEL_LSB        = 0;
  localparam int unsigned CH_SEL_MSB        = 3;
  localparam int unsigned CH_VAL_LSB        = 4;
  localparam int unsigned SRC_LSB           = 0;
  localparam int unsigned SRC_MSB           = 2;
  localparam int unsigned SRC_GIVEN_BIT     = 3;
  localparam int unsigned STAT_PENDING_BIT  = 0;
  localparam int unsigned STAT_STALL_BIT    = 1;
  localparam int unsigned STAT_PACING_BIT   = 2;
  localparam logic [15:0] OUT_RESET         = 16'h0000;
  localparam logic [7:0]  ERR_NONE          = 8'h00;
  localparam logic [7:0]  ERR_TOO_MANY_ARGS = 8'h15;
  localparam logic [7:0]  LIST_COUNT_RESET  = 8'h00;
  localparam real         CLK_MHZ           = 25.0;
  localparam real         MAX_WRITE_RATE_HZ = 189000.0;
  localparam int unsigned WRITE_GAP_CYCLES  =
    int'($floor(CLK_MHZ * 1.0e6 / MAX_WRITE_RATE_HZ));
  typedef enum logic [2:0] {
    SRC_HOLD     = 3'h0,
    SRC_EXTERNAL = 3'h1,
    SRC_WRITE    = 3'h2,
    SRC_ONE_SHOT = 3'h3,
    SRC_SYSTEM   = 3'h4
  } source_t;
  typedef enum logic [0:0] {
    PACE_IMMEDIATE = 1'b0,
    PACE_WAIT      = 1'b1
  } pacing_t;
  typedef enum logic [1:0] {
    WS_IDLE  = 2'b01,
    WS_STALL = 2'b10
  } wstate_t;
endpackage : dro_pkg

//--- verilog/fall_detect.sv
// falling edge detector with two-stage synchroniser.
// assumes the input may be asynchronous to core_clk.
`timescale 1ns/100ps
module fall_detect
  import dro_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      fall_pulse
);
  logic sync_a;
  logic sync_b;
  logic last;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      last   <= 1'b1;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      last   <= sync_b;
    end
  end
  assign fall_pulse = last & ~sync_b;
  property p_one_pulse;
    @(posedge core_clk) disable iff (reset)
    fall_pulse |=> !fall_pulse;
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("fall pulse longer than one cycle");
endmodule : fall_detect

//--- verilog/second_rank.sv
// second rank output register driving the user terminals.
// assumes transfer pulses are one cycle wide.
`timescale 1ns/100ps
module second_rank
  import dro_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             transfer,
  input  wire logic [WIDTH-1:0] first_rank,
  output logic      [WIDTH-1:0] channel_out
);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      channel_out <= OUT_RESET;
    end else if (transfer) begin
      channel_out <= first_rank;
    end
  end
  property p_copy;
    @(posedge core_clk) disable iff (reset)
    transfer |=> channel_out == $past(first_rank);
  endproperty
  a_copy: assert property (p_copy)
    else $error("second rank did not copy first rank");
  property p_hold;
    @(posedge core_clk) disable iff (reset)
    !transfer |=> $stable(channel_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("outputs changed without transfer");
endmodule : second_rank

//--- verif/trigger_partner.sv
// far-side trigger model: external trigger terminal and mainframe system trigger.
// assumes tasks are called from the bench between clock edges.
`timescale 1ns/100ps
module trigger_partner (
  input  wire logic core_clk,
  output logic      transfer_trigger_input,
  output logic      system_trigger_event
);
  // terminal idles high through its pull-up
  initial begin
    transfer_trigger_input = 1'b1;
    system_trigger_event   = 1'b0;
  end

  // one high-to-low pulse, driven just after the clock edge
  task automatic fall_edge();
    @(posedge core_clk);
    transfer_trigger_input <= 1'b0;
    repeat (6) @(posedge core_clk);
    transfer_trigger_input <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : fall_edge

  // one-cycle system trigger event
  task automatic sys_pulse();
    @(posedge core_clk);
    system_trigger_event <= 1'b1;
    @(posedge core_clk);
    system_trigger_event <= 1'b0;
  endtask : sys_pulse
endmodule : trigger_partner

//--- verif/tb_top.sv
// testbench for the double rank digital output port.
// assumes the design package and trigger_partner are compiled first.
`timescale 1ns/100ps
module tb_top
  import dro_pkg::*;
;
  logic              core_clk;
  logic              reset;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_write;
  logic              reg_read;
  logic [31:0]       reg_rdata;
  logic              transfer_trigger_input;
  logic              system_trigger_event;
  logic [WIDTH-1:0]  channel_out;
  logic              word_write_ready;
  logic              transfer_pulse;
  int                err_total;
  int                checks;
  int                cyc;
  int                n_pulse;
  int                base;
  logic [15:0]       words [4] = '{16'h0041, 16'h0088, 16'h8000, 16'h0002};

  double_rank_digital_output DUT (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .transfer_trigger_input(transfer_trigger_input),
    .system_trigger_event(system_trigger_event), .channel_out(channel_out),
    .word_write_ready(word_write_ready), .transfer_pulse(transfer_pulse));

  trigger_partner peer (
    .core_clk(core_clk), .transfer_trigger_input(transfer_trigger_input),
    .system_trigger_event(system_trigger_event));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // counts transfer pulses and cuts a hang short
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (reset) n_pulse <= 0;
    else if (transfer_pulse === 1'b1) n_pulse <= n_pulse + 1;
    if (cyc == 3000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : step

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk("reg_rdata", exp, reg_rdata);
  endtask : rd_chk

  task automatic out_is(input logic [15:0] exp);
    chk("channel_out", {16'h0000, exp}, {16'h0000, channel_out});
  endtask : out_is

  task automatic wrap_up();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    err_total = 0; checks = 0; cyc = 0;
    reset = 1'b1; reg_write = 1'b0; reg_read = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    step(1);
    out_is(OUT_RESET);
    chk("ready", 32'h1, {31'h0, word_write_ready});
    rd_chk(SOURCE_ADDR, {29'h0, SRC_WRITE});
    rd_chk(PACING_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(SLOT_WORD_ADDR, {16'h0000, words[i]});
      #1 chk("transfer_pulse", 32'h1, {31'h0, transfer_pulse});
      step(1);
      out_is(words[i]);
    end
    // channel writes: select in low nibble, value above it
    wr(CHANNEL_ADDR, 32'h0000_0053);
    wr(CHANNEL_ADDR, 32'h8000_0004);
    step(2);
    out_is(16'h001A);
    wr(CHANNEL_ADDR, 32'h0000_0001);
    step(2);
    out_is(16'h0018);
    base = n_pulse;
    wr(SOURCE_ADDR, 32'h8);
    wr(SLOT_WORD_ADDR, 32'h1234);
    wr(SLOT_WORD_ADDR, 32'h0545);
    step(3);
    out_is(16'h0018);
    rd_chk(FIRST_RANK_ADDR, 32'h0545);
    chk("pulses", base, n_pulse);
    wr(SOURCE_ADDR, 32'h9);
    wr(SLOT_WORD_ADDR, 32'h00C3);
    step(3);
    out_is(16'h0018);
    base = n_pulse;
    peer.fall_edge();
    step(1);
    out_is(16'h00C3);
    chk("pulses", base + 1, n_pulse);
    wr(PACING_ADDR, 32'h1);
    wr(SLOT_WORD_ADDR, 32'h0F0F);
    wr(SLOT_WORD_ADDR, 32'hF0F0);
    wr(SLOT_WORD_ADDR, 32'hFFFF);
    step(1);
    chk("ready", 32'h0, {31'h0, word_write_ready});
    rd_chk(STATUS_ADDR, 32'((1 << STAT_PACING_BIT) | (1 << STAT_STALL_BIT) | 1));
    rd_chk(FIRST_RANK_ADDR, 32'h0F0F);
    peer.fall_edge();
    step(1);
    out_is(16'h0F0F);
    rd_chk(SECOND_RANK_ADDR, 32'h0F0F);
    rd_chk(FIRST_RANK_ADDR, 32'hF0F0);
    wr(CHANNEL_ADDR, 32'h0000_0010);
    step(1);
    chk("ready", 32'h1, {31'h0, word_write_ready});
    rd_chk(FIRST_RANK_ADDR, 32'hF0F1);
    wr(SOURCE_ADDR, 32'hC);
    base = n_pulse;
    peer.sys_pulse();
    step(1);
    out_is(16'hF0F1);
    chk("pulses", base + 1, n_pulse);
    wr(SLOT_WORD_ADDR, 32'h3C3C);
    base = n_pulse;
    wr(SOURCE_ADDR, 32'h0);
    step(2);
    out_is(16'h3C3C);
    chk("pulses", base + 1, n_pulse);
    rd_chk(SOURCE_ADDR, {29'h0, SRC_ONE_SHOT});
    wr(SLOT_WORD_ADDR, 32'h5A5A);
    step(3);
    out_is(16'h3C3C);
    base = n_pulse;
    wr(SOURCE_ADDR, 32'hA);
    step(3);
    chk("pulses", base, n_pulse);
    wr(SLOT_WORD_ADDR, 32'h1111);
    wr(SLOT_WORD_ADDR, 32'h2222);
    step(2);
    out_is(16'h2222);
    chk("pulses", base + 2, n_pulse);
    wr(LIST_COUNT_ADDR, 32'h2);
    base = n_pulse;
    wr(SLOT_WORD_ADDR, 32'h0001);
    wr(SLOT_WORD_ADDR, 32'h0002);
    step(1);
    rd_chk(ERROR_ADDR, {24'h0, ERR_NONE});
    wr(SLOT_WORD_ADDR, 32'h0004);
    step(2);
    rd_chk(ERROR_ADDR, {24'h0, ERR_TOO_MANY_ARGS});
    chk("pulses", base + 3, n_pulse);
    wr(ERROR_ADDR, 32'h0);
    rd_chk(ERROR_ADDR, {24'h0, ERR_NONE});
    rd_chk(4'hF, 32'h0);
    wrap_up();
  end
endmodule : tb_top
